// file: dec_pkg.sv
// Shared constants and state type for the 8b/10b receive decoder
`default_nettype none
package dec_pkg;
	// Wishbone byte addresses of the register file
	localparam logic [4:0] ADR_STATUS = 5'h00;
	localparam logic [4:0] ADR_MASK   = 5'h04;
	localparam logic [4:0] ADR_STATE  = 5'h08;
	localparam logic [4:0] ADR_ERRCNT = 5'h0c;

	// Event bit positions, shared by status and mask
	localparam int unsigned EV_CODE_ERR  = 0;
	localparam int unsigned EV_RD_ERR    = 1;
	localparam int unsigned EV_IDLE_DROP = 2;
	localparam int unsigned EV_W         = 3;
	localparam int unsigned CNT_W        = 16;

	localparam logic [EV_W-1:0]  STATUS_RST = 3'h0;
	localparam logic [EV_W-1:0]  MASK_RST   = 3'h0;
	localparam logic [CNT_W-1:0] CNT_MAX    = 16'hffff;
	// Running disparity after reset: negative
	localparam logic             RD_RST     = 1'b0;

	localparam logic [7:0] IDLE_BYTE = 8'hbc;
	localparam logic [4:0] K28_X     = 5'h1c;
	// Six-bit K28 forms, written abcdei with a as the top bit
	localparam logic [5:0] K28_NEG6  = 6'h0f;
	localparam logic [5:0] K28_POS6  = 6'h30;
	// Whole characters as seen on the coded input, a at bit 0
	localparam logic [9:0] CODE_K28_5_NEG = 10'h17c;
	localparam logic [9:0] CODE_K28_5_POS = 10'h283;
	localparam logic [9:0] CODE_D0_0_NEG  = 10'h0b9;
	localparam logic [9:0] CODE_ZERO      = 10'h000;

	typedef struct packed {
		logic             s1_en;
		logic             s1_idle_del;
		logic [9:0]       s1_code;
		logic             rd;
		logic             valid;
		logic [7:0]       dout;
		logic             k;
		logic             code_err;
		logic             rd_err;
		logic [EV_W-1:0]  status;
		logic [EV_W-1:0]  mask;
		logic [CNT_W-1:0] err_cnt;
		logic             ack;
		logic [31:0]      rdata;
		logic             irq;
	} dec_state_t;

	localparam dec_state_t STATE_RST = '{
		s1_en: 1'b0, s1_idle_del: 1'b0, s1_code: 10'h000, rd: RD_RST,
		valid: 1'b0, dout: 8'h00, k: 1'b0, code_err: 1'b0, rd_err: 1'b0,
		status: STATUS_RST, mask: MASK_RST, err_cnt: 16'h0000,
		ack: 1'b0, rdata: 32'h0000_0000, irq: 1'b0};
endpackage
`default_nettype wire

// file: dec_six_five.sv
// Six-bit subblock decoder: abcdei to EDCBA with disparity attributes
`default_nettype none
module dec_six_five (
	input  wire logic [5:0] i_code,
	output logic      [4:0] o_val,
	output logic            o_ok,
	output logic            o_pos,
	output logic            o_neg,
	output logic            o_need_neg,
	output logic            o_need_pos
);
	logic [2:0] weight;

	always_comb
	begin
		weight = 3'h0;
		for (int b = 0; b < 6; b++)
			weight = weight + {2'h0, i_code[b]};
		o_pos      = weight == 3'h4;
		o_neg      = weight == 3'h2;
		// Balanced D7 forms still carry a disparity side
		o_need_neg = o_pos || i_code == 6'h38;
		o_need_pos = o_neg || i_code == 6'h07;
		o_ok       = 1'b1;
		unique case (i_code)
			6'h27, 6'h18: o_val = 5'h00;
			6'h1d, 6'h22: o_val = 5'h01;
			6'h2d, 6'h12: o_val = 5'h02;
			6'h31:        o_val = 5'h03;
			6'h35, 6'h0a: o_val = 5'h04;
			6'h29:        o_val = 5'h05;
			6'h19:        o_val = 5'h06;
			6'h38, 6'h07: o_val = 5'h07;
			6'h39, 6'h06: o_val = 5'h08;
			6'h25:        o_val = 5'h09;
			6'h15:        o_val = 5'h0a;
			6'h34:        o_val = 5'h0b;
			6'h0d:        o_val = 5'h0c;
			6'h2c:        o_val = 5'h0d;
			6'h1c:        o_val = 5'h0e;
			6'h17, 6'h28: o_val = 5'h0f;
			6'h1b, 6'h24: o_val = 5'h10;
			6'h23:        o_val = 5'h11;
			6'h13:        o_val = 5'h12;
			6'h32:        o_val = 5'h13;
			6'h0b:        o_val = 5'h14;
			6'h2a:        o_val = 5'h15;
			6'h1a:        o_val = 5'h16;
			6'h3a, 6'h05: o_val = 5'h17;
			6'h33, 6'h0c: o_val = 5'h18;
			6'h26:        o_val = 5'h19;
			6'h16:        o_val = 5'h1a;
			6'h36, 6'h09: o_val = 5'h1b;
			6'h0e:        o_val = 5'h1c;
			6'h2e, 6'h11: o_val = 5'h1d;
			6'h1e, 6'h21: o_val = 5'h1e;
			6'h2b, 6'h14: o_val = 5'h1f;
			6'h0f, 6'h30: o_val = 5'h1c;
			default:
			begin
				o_val = 5'h00;
				o_ok  = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// file: dec_four_three.sv
// Four-bit subblock decoder: fghj to HGF with disparity attributes
`default_nettype none
module dec_four_three (
	input  wire logic [3:0] i_code,
	output logic      [2:0] o_val,
	output logic            o_ok,
	output logic            o_alt,
	output logic            o_pos,
	output logic            o_neg,
	output logic            o_need_neg,
	output logic            o_need_pos
);
	logic [2:0] weight;

	always_comb
	begin
		weight = 3'h0;
		for (int b = 0; b < 4; b++)
			weight = weight + {2'h0, i_code[b]};
		o_pos      = weight == 3'h3;
		o_neg      = weight == 3'h1;
		o_need_neg = o_pos || i_code == 4'hc;
		o_need_pos = o_neg || i_code == 4'h3;
		o_ok       = 1'b1;
		o_alt      = 1'b0;
		unique case (i_code)
			4'hb, 4'h4: o_val = 3'h0;
			4'h9:       o_val = 3'h1;
			4'h5:       o_val = 3'h2;
			4'hc, 4'h3: o_val = 3'h3;
			4'hd, 4'h2: o_val = 3'h4;
			4'ha:       o_val = 3'h5;
			4'h6:       o_val = 3'h6;
			4'he, 4'h1: o_val = 3'h7;
			4'h7, 4'h8:
			begin
				o_val = 3'h7;
				o_alt = 1'b1;
			end
			default:
			begin
				o_val = 3'h0;
				o_ok  = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// file: dec_decoder.sv
// Two-stage 8b/10b receive decoder with Wishbone status and interrupt
// Notes on behaviour
// - While idle removal is high, a received K28.5 keeps valid low.
// - Upstream raises enable per word to decode; only enabled words are decoded.
// - Override high selects the seed as current disparity, else the tracked one.
// - Valid is high when a new decoded byte, other than a dropped idle, stands on the byte output.
// - The result is an 8-bit byte, data value or control code.
// - Control flag high for a control character, low for a data byte.
// - Bad-code flag high when the character is not in the code set.
// - Disparity fault high when the character breaks the running disparity.
// - Disparity output shows the disparity after the byte now shown.
// - A chained disparity output feeds the seed of a second decoder.
// - A word sampled on edge n has its result sampled on edge n+2.
// - The active-low reset clears every register at once.
`default_nettype none
module dec_decoder (
	input  wire logic        I_CLK,
	input  wire logic        I_RESETN,
	input  wire logic        I_ENABLE,
	input  wire logic        I_IDLE_DEL,
	input  wire logic [9:0]  I_DATA,
	input  wire logic        I_RD_SEED,
	input  wire logic        I_RD_OVR,
	output logic             O_VALID,
	output logic      [7:0]  O_BYTE,
	output logic             O_K,
	output logic             O_CODE_ERR,
	output logic             O_RD_ERR,
	output logic             O_RD,
	output logic             O_RD_CHAIN,
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [4:0]  I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	output logic      [31:0] O_WB_DAT,
	output logic             O_WB_ACK,
	output logic             O_IRQ
);
	dec_pkg::dec_state_t st;
	dec_pkg::dec_state_t next_st;

	logic [5:0] six_raw;
	logic [3:0] four_raw;
	logic [3:0] four_dec;
	logic       inv4;
	logic       k28_form;
	logic [4:0] six_val;
	logic       six_ok;
	logic       six_pos;
	logic       six_neg;
	logic       six_need_neg;
	logic       six_need_pos;
	logic [2:0] four_val;
	logic       four_ok;
	logic       four_alt;
	logic       f_pos_x;
	logic       f_neg_x;
	logic       f_need_neg_x;
	logic       f_need_pos_x;
	logic       four_pos;
	logic       four_neg;
	logic       four_need_neg;
	logic       four_need_pos;
	logic       rd_in;
	logic       rd_mid;
	logic       rd_after;
	logic       is_k;
	logic       bad_code;
	logic       bad_rd;
	logic [7:0] dec_byte;
	logic       is_idle;
	logic       drop;
	logic       wb_hit;
	logic [4:0] wb_adr;
	logic       st_clear;
	logic       cnt_clear;
	logic [dec_pkg::EV_W-1:0] events;
	logic [dec_pkg::CNT_W-1:0] cnt_base;

	localparam int unsigned EV_W_L = dec_pkg::EV_W;

	// Data or control x values that may carry the alternate seven
	function automatic logic alt_allowed(input logic [4:0] x, input logic k);
		if (k)
			alt_allowed = x == 5'h17 || x == 5'h1b || x == 5'h1c || x == 5'h1d
				|| x == 5'h1e;
		else
			alt_allowed = x == 5'h0b || x == 5'h0d || x == 5'h0e || x == 5'h11
				|| x == 5'h12 || x == 5'h14;
	endfunction

	// Bit a is I_DATA[0]; the subblocks are listed a..i and f..j
	assign six_raw  = {st.s1_code[0], st.s1_code[1], st.s1_code[2],
		st.s1_code[3], st.s1_code[4], st.s1_code[5]};
	assign four_raw = {st.s1_code[6], st.s1_code[7], st.s1_code[8],
		st.s1_code[9]};
	assign k28_form = six_raw == dec_pkg::K28_NEG6 || six_raw == dec_pkg::K28_POS6;
	// Positive K28 form pairs with the complemented four-bit table
	assign inv4     = six_raw == dec_pkg::K28_POS6;
	assign four_dec = inv4 ? ~four_raw : four_raw;

	dec_six_five u_six (
		.i_code     (six_raw),
		.o_val      (six_val),
		.o_ok       (six_ok),
		.o_pos      (six_pos),
		.o_neg      (six_neg),
		.o_need_neg (six_need_neg),
		.o_need_pos (six_need_pos)
	);

	dec_four_three u_four (
		.i_code     (four_dec),
		.o_val      (four_val),
		.o_ok       (four_ok),
		.o_alt      (four_alt),
		.o_pos      (f_pos_x),
		.o_neg      (f_neg_x),
		.o_need_neg (f_need_neg_x),
		.o_need_pos (f_need_pos_x)
	);

	always_comb
	begin
		four_pos      = inv4 ? f_neg_x : f_pos_x;
		four_neg      = inv4 ? f_pos_x : f_neg_x;
		four_need_neg = inv4 ? f_need_pos_x : f_need_neg_x;
		four_need_pos = inv4 ? f_need_neg_x : f_need_pos_x;
		rd_in    = I_RD_OVR ? I_RD_SEED : st.rd;
		rd_mid   = six_pos ? 1'b1 : (six_neg ? 1'b0 : rd_in);
		rd_after = four_pos ? 1'b1 : (four_neg ? 1'b0 : rd_mid);
		is_k     = k28_form || (four_alt && alt_allowed(six_val, 1'b1));
		dec_byte = {four_val, six_val};
		// Primary seven next to x that already ends in the same run
		bad_code = !six_ok || !four_ok
			|| (four_alt && !alt_allowed(six_val, is_k))
			|| (four_raw == 4'he && (six_val == 5'h11 || six_val == 5'h12
				|| six_val == 5'h14) && !k28_form)
			|| (four_raw == 4'h1 && (six_val == 5'h0b || six_val == 5'h0d
				|| six_val == 5'h0e) && !k28_form);
		bad_rd   = (six_need_neg && rd_in) || (six_need_pos && !rd_in)
			|| (four_need_neg && rd_mid) || (four_need_pos && !rd_mid);
		is_idle  = is_k && dec_byte == dec_pkg::IDLE_BYTE;
		drop     = st.s1_idle_del && is_idle;
	end

	always_comb
	begin
		next_st = st;
		// Stage one: capture the word and its qualifiers
		next_st.s1_en       = I_ENABLE;
		next_st.s1_idle_del = I_IDLE_DEL;
		next_st.s1_code     = I_DATA;
		// Stage two: decoded result, visible for sampling on edge n+2
		next_st.valid    = st.s1_en && !drop;
		next_st.code_err = st.s1_en && bad_code;
		next_st.rd_err   = st.s1_en && bad_rd;
		if (st.s1_en)
		begin
			next_st.dout = dec_byte;
			next_st.k    = is_k;
			next_st.rd   = rd_after;
		end

		// Wishbone classic slave, one wait state, ack for one cycle
		wb_hit    = I_WB_CYC && I_WB_STB && !st.ack;
		wb_adr    = {I_WB_ADR[4:2], 2'h0};
		st_clear  = 1'b0;
		cnt_clear = 1'b0;
		next_st.ack   = wb_hit;
		next_st.rdata = 32'h0000_0000;
		if (wb_hit)
		begin
			if (I_WB_WE)
			begin
				if (wb_adr == dec_pkg::ADR_MASK && I_WB_SEL[0])
					next_st.mask = I_WB_DAT[EV_W_L-1:0];
				if (wb_adr == dec_pkg::ADR_ERRCNT && |I_WB_SEL)
					cnt_clear = 1'b1;
			end
			else
			begin
				unique case (wb_adr)
					dec_pkg::ADR_STATUS:
					begin
						next_st.rdata = {29'h0, st.status};
						st_clear = 1'b1;
					end
					dec_pkg::ADR_MASK:
						next_st.rdata = {29'h0, st.mask};
					dec_pkg::ADR_STATE:
						next_st.rdata = {31'h0, st.rd};
					dec_pkg::ADR_ERRCNT:
						next_st.rdata = {16'h0, st.err_cnt};
					default:
						next_st.rdata = 32'h0000_0000;
				endcase
			end
		end

		// Sticky events; a new event wins over the read clear
		events = '0;
		events[dec_pkg::EV_CODE_ERR]  = st.s1_en && bad_code;
		events[dec_pkg::EV_RD_ERR]    = st.s1_en && bad_rd;
		events[dec_pkg::EV_IDLE_DROP] = st.s1_en && drop;
		next_st.status = (st_clear ? '0 : st.status) | events;
		cnt_base = cnt_clear ? '0 : st.err_cnt;
		next_st.err_cnt = cnt_base;
		if (events[dec_pkg::EV_CODE_ERR] && cnt_base != dec_pkg::CNT_MAX)
			next_st.err_cnt = cnt_base + 16'h0001;
		next_st.irq = |(next_st.status & next_st.mask);
	end

	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
			st <= dec_pkg::STATE_RST;
		else
			st <= next_st;
	end

	assign O_VALID    = st.valid;
	assign O_BYTE     = st.dout;
	assign O_K        = st.k;
	assign O_CODE_ERR = st.code_err;
	assign O_RD_ERR   = st.rd_err;
	assign O_RD       = st.rd;
	// Chain output stays combinational so a partner can use it this cycle
	assign O_RD_CHAIN = rd_after;
	assign O_WB_DAT   = st.rdata;
	assign O_WB_ACK   = st.ack;
	assign O_IRQ      = st.irq;

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RESETN);

	property p_idle_dropped;
		I_ENABLE && I_IDLE_DEL
			&& (I_DATA == dec_pkg::CODE_K28_5_NEG || I_DATA == dec_pkg::CODE_K28_5_POS)
			|-> ##2 !O_VALID;
	endproperty
	a_idle_dropped: assert property (p_idle_dropped)
		else $error("idle character was not dropped");

	property p_valid_latency;
		I_ENABLE && !I_IDLE_DEL ##1 1'b1 |-> ##1 O_VALID;
	endproperty
	a_valid_latency: assert property (p_valid_latency)
		else $error("decoded byte not valid two cycles after input");

	property p_no_enable_no_valid;
		!I_ENABLE |-> ##2 !O_VALID;
	endproperty
	a_no_enable_no_valid: assert property (p_no_enable_no_valid)
		else $error("valid raised for a cycle without enable");

	property p_valid_has_cause;
		O_VALID |-> $past(I_ENABLE, 2);
	endproperty
	a_valid_has_cause: assert property (p_valid_has_cause)
		else $error("valid without an enabled input word");

	property p_rd_held;
		!st.s1_en |=> $stable(O_RD);
	endproperty
	a_rd_held: assert property (p_rd_held)
		else $error("disparity moved without an enabled word");

	property p_comma_decode;
		I_ENABLE && I_DATA == dec_pkg::CODE_K28_5_NEG
			|-> ##2 O_K && O_BYTE == dec_pkg::IDLE_BYTE && !O_CODE_ERR;
	endproperty
	a_comma_decode: assert property (p_comma_decode)
		else $error("comma not decoded as control 0xbc");

	property p_data_decode;
		I_ENABLE && I_DATA == dec_pkg::CODE_D0_0_NEG
			|-> ##2 !O_K && O_BYTE == 8'h00 && !O_CODE_ERR;
	endproperty
	a_data_decode: assert property (p_data_decode)
		else $error("data zero not decoded as data byte zero");

	property p_bad_code;
		I_ENABLE && I_DATA == dec_pkg::CODE_ZERO |-> ##2 O_CODE_ERR;
	endproperty
	a_bad_code: assert property (p_bad_code)
		else $error("all-zero character not flagged as bad code");

	property p_seed_fault;
		st.s1_en && I_RD_OVR && I_RD_SEED && st.s1_code == dec_pkg::CODE_K28_5_NEG
			|=> O_RD_ERR && O_RD;
	endproperty
	a_seed_fault: assert property (p_seed_fault)
		else $error("positive seed not used for disparity check");

	property p_tracked_rd;
		st.s1_en && !I_RD_OVR && !st.rd && st.s1_code == dec_pkg::CODE_K28_5_NEG
			|=> !O_RD_ERR && O_RD;
	endproperty
	a_tracked_rd: assert property (p_tracked_rd)
		else $error("disparity after comma not positive");

	property p_rd_fault;
		st.s1_en && !I_RD_OVR && st.rd && st.s1_code == dec_pkg::CODE_K28_5_NEG
			|=> O_RD_ERR;
	endproperty
	a_rd_fault: assert property (p_rd_fault)
		else $error("negative comma at positive disparity not flagged");

	property p_chain_matches;
		st.s1_en |=> O_RD == $past(O_RD_CHAIN);
	endproperty
	a_chain_matches: assert property (p_chain_matches)
		else $error("chained disparity differs from registered one");

	property p_irq_level;
		O_IRQ |-> |(st.status & st.mask);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt without an unmasked status bit");

	c_idle_drop: cover property (I_ENABLE && I_IDLE_DEL
		&& I_DATA == dec_pkg::CODE_K28_5_POS ##2 !O_VALID);
	c_code_err: cover property (O_CODE_ERR && O_IRQ);
	c_override: cover property (st.s1_en && I_RD_OVR ##1 O_VALID);
	c_status_read: cover property (O_WB_ACK && !I_WB_WE
		&& I_WB_ADR[4:2] == 3'h0 ##1 1'b1);
endmodule
`default_nettype wire

// file: dec_up_model.sv
// Upstream deserializer model that feeds coded words to the decoder
`default_nettype none
module dec_up_model (
	input  wire logic       i_clk,
	output logic            o_en,
	output logic            o_idle_del,
	output logic      [9:0] o_data,
	output logic            o_seed,
	output logic            o_ovr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic p_seed;
	logic p_ovr;

	initial
	begin
		o_en = 1'b0;
		o_idle_del = 1'b0;
		o_data = 10'h155;
		o_seed = 1'b0;
		o_ovr = 1'b0;
		p_seed = 1'b0;
		p_ovr = 1'b0;
	end

	// Called right after a rising edge
	task automatic send(input logic en, input logic [9:0] code, input logic idle,
		input logic ovr, input logic seed);
		o_en <= en;
		// Unused cycles show the inverse of the last word
		o_data <= en ? code : ~o_data;
		o_idle_del <= idle;
		p_ovr <= ovr;
		p_seed <= seed;
	endtask

	// Seed and override trail their word by one cycle
	always @(posedge i_clk)
	begin
		o_ovr <= p_ovr;
		o_seed <= p_seed;
	end
endmodule
`default_nettype wire

// file: dec_decoder_test.sv
// Self-checking testbench of the 8b/10b receive decoder
`default_nettype none
module dec_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		int         due;
		logic [5:0] m;
		logic       v;
		logic [7:0] b;
		logic       k;
		logic       ce;
		logic       re;
		logic       rd;
	} dec_exp_t;

	logic        I_CLK;
	logic        I_RESETN;
	logic        en;
	logic        idle;
	logic [9:0]  data;
	logic        seed;
	logic        ovr;
	logic        O_VALID;
	logic [7:0]  O_BYTE;
	logic        O_K;
	logic        O_CODE_ERR;
	logic        O_RD_ERR;
	logic        O_RD;
	logic        O_RD_CHAIN;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [4:0]  wb_adr;
	logic [31:0] wb_dat;
	logic [31:0] O_WB_DAT;
	logic        O_WB_ACK;
	logic        O_IRQ;
	logic [31:0] rdat;
	logic [9:0]  data2;
	logic        O_RD2;
	logic        O_RD_ERR2;
	int          err_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	dec_exp_t    q[$];
	dec_exp_t    e;

	dec_up_model up (.i_clk(I_CLK), .o_en(en), .o_idle_del(idle), .o_data(data),
		.o_seed(seed), .o_ovr(ovr));

	dec_decoder dut (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_ENABLE(en), .I_IDLE_DEL(idle),
		.I_DATA(data), .I_RD_SEED(seed), .I_RD_OVR(ovr), .O_VALID(O_VALID),
		.O_BYTE(O_BYTE), .O_K(O_K), .O_CODE_ERR(O_CODE_ERR), .O_RD_ERR(O_RD_ERR),
		.O_RD(O_RD), .O_RD_CHAIN(O_RD_CHAIN), .I_WB_CYC(wb_cyc), .I_WB_STB(wb_stb),
		.I_WB_WE(wb_we), .I_WB_ADR(wb_adr), .I_WB_SEL(4'hf), .I_WB_DAT(wb_dat),
		.O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_IRQ(O_IRQ));

	// Second lane takes its disparity from the first lane's chain output
	dec_decoder dut_b (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_ENABLE(en), .I_IDLE_DEL(1'b0),
		.I_DATA(data2), .I_RD_SEED(O_RD_CHAIN), .I_RD_OVR(1'b1), .O_VALID(), .O_BYTE(),
		.O_K(), .O_CODE_ERR(), .O_RD_ERR(O_RD_ERR2), .O_RD(O_RD2), .O_RD_CHAIN(),
		.I_WB_CYC(1'b0), .I_WB_STB(1'b0), .I_WB_WE(1'b0), .I_WB_ADR(5'h00),
		.I_WB_SEL(4'h0), .I_WB_DAT(32'h0), .O_WB_DAT(), .O_WB_ACK(),
		.O_IRQ());

	initial
	begin
		I_CLK = 1'b0;
		forever #10 I_CLK = ~I_CLK;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Mask bits: valid, byte and flag, code error, disparity error, disparity, chain
	task automatic word(input logic w_en, input logic [9:0] c, input logic w_idle,
		input logic w_ovr, input logic w_seed, input logic [5:0] m, input logic v,
		input logic [7:0] b, input logic k, input logic ce, input logic re, input logic rd);
		dec_exp_t x;
		@(posedge I_CLK);
		up.send(w_en, c, w_idle, w_ovr, w_seed);
		x = '{cyc + 3, m, v, b, k, ce, re, rd};
		q.push_back(x);
	endtask

	// Results of a word are sampled three edges after it is driven, the chain output two edges after
	always @(posedge I_CLK)
	begin
		cyc <= cyc + 1;
		foreach (q[i])
			if (q[i].m[5] && q[i].due == cyc + 1)
				check(O_RD_CHAIN, q[i].rd);
		if (q.size() > 0 && q[0].due == cyc)
		begin
			e = q.pop_front();
			if (e.m[0])
				check(O_VALID, e.v);
			if (e.m[1])
				check({O_K, O_BYTE}, {e.k, e.b});
			if (e.m[2])
				check(O_CODE_ERR, e.ce);
			if (e.m[3])
				check(O_RD_ERR, e.re);
			if (e.m[4])
				check(O_RD, e.rd);
		end
	end

	task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
		@(posedge I_CLK);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		// Only the watchdog ends a wait for the answer
		do
			@(posedge I_CLK);
		while (O_WB_ACK !== 1'b1);
		rdat = O_WB_DAT;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge I_CLK);
	endtask

	task automatic rreg(input logic [4:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(rdat, exp);
	endtask

	task automatic t_stream();
		word(1, dec_pkg::CODE_K28_5_NEG, 0, 0, 0, 6'h3f, 1, 8'hbc, 1, 0, 0, 1);
		data2 <= dec_pkg::CODE_K28_5_POS;
		word(1, dec_pkg::CODE_K28_5_POS, 0, 0, 0, 6'h3f, 1, 8'hbc, 1, 0, 0, 0);
		data2 <= dec_pkg::CODE_K28_5_NEG;
		word(1, dec_pkg::CODE_D0_0_NEG, 0, 0, 0, 6'h3f, 1, 8'h00, 0, 0, 0, 0);
		@(posedge I_CLK);
		check(O_RD2, 1'b0);
		check(O_RD_ERR2, 1'b0);
		@(posedge I_CLK);
		check(O_RD2, 1'b1);
		check(O_RD_ERR2, 1'b0);
		repeat (2) @(posedge I_CLK);
		$display("Test stream done");
	endtask

	task automatic t_hold();
		word(0, 10'h0, 0, 0, 0, 6'h11, 0, 8'h0, 0, 0, 0, 0);
		word(1, dec_pkg::CODE_K28_5_NEG, 1, 0, 0, 6'h3d, 0, 8'h0, 0, 0, 0, 1);
		repeat (4) @(posedge I_CLK);
		$display("Test hold and idle drop done");
	endtask

	task automatic t_err();
		word(1, dec_pkg::CODE_ZERO, 0, 0, 0, 6'h14, 0, 8'h0, 0, 1, 0, 1);
		word(1, dec_pkg::CODE_K28_5_NEG, 0, 1, 1, 6'h38, 0, 8'h0, 0, 0, 1, 1);
		word(1, dec_pkg::CODE_K28_5_NEG, 0, 1, 0, 6'h3f, 1, 8'hbc, 1, 0, 0, 1);
		// Tracked positive disparity meets a negative-form comma
		word(1, dec_pkg::CODE_K28_5_NEG, 0, 0, 0, 6'h3f, 1, 8'hbc, 1, 0, 1, 1);
		word(0, 10'h0, 0, 0, 0, 6'h00, 0, 8'h0, 0, 0, 0, 0);
		repeat (4) @(posedge I_CLK);
		$display("Test errors and override done");
	endtask

	task automatic t_regs();
		rreg(dec_pkg::ADR_STATUS, 32'h7);
		rreg(dec_pkg::ADR_STATUS, 32'h0);
		rreg(dec_pkg::ADR_ERRCNT, 32'h1);
		wb(1'b1, dec_pkg::ADR_ERRCNT, 32'h0);
		rreg(dec_pkg::ADR_ERRCNT, 32'h0);
		rreg(5'h10, 32'h0);
		rreg(dec_pkg::ADR_STATE, 32'h1);
		rreg(dec_pkg::ADR_MASK, 32'h0);
		wb(1'b1, dec_pkg::ADR_MASK, 32'h1);
		rreg(dec_pkg::ADR_MASK, 32'h1);
		check(O_IRQ, 1'b0);
		word(1, dec_pkg::CODE_ZERO, 0, 0, 0, 6'h04, 0, 8'h0, 0, 1, 0, 0);
		word(0, 10'h0, 0, 0, 0, 6'h00, 0, 8'h0, 0, 0, 0, 0);
		repeat (5) @(posedge I_CLK);
		check(O_IRQ, 1'b1);
		rreg(dec_pkg::ADR_STATUS, 32'h1);
		repeat (3) @(posedge I_CLK);
		check(O_IRQ, 1'b0);
		$display("Test registers and interrupt done");
	endtask

	initial
	begin
		I_RESETN = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 5'h00;
		wb_dat = 32'h0;
		data2 = dec_pkg::CODE_ZERO;
		repeat (16) @(posedge I_CLK);
		I_RESETN <= 1'b1;
		t_stream();
		t_hold();
		t_err();
		t_regs();
		print_verdict();
	end

	initial
	begin
		repeat (5000) @(posedge I_CLK);
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
